// ---- verification/prcp_remote_node.sv ----
`timescale 1ns/1ps
module prcp_remote_node (
    // handshake
    input  wire logic        pclk,
    input  wire logic        rx_ready,
    // command towards the node
    output logic             rx_valid,
    output logic      [7:0]  rx_cmd,
    output logic             rx_service_ack,
    output logic             rx_is_ack,
    output logic      [63:0] rx_payload
);
    initial begin
        rx_valid = 1'b0;
        rx_cmd = 8'h00;
        rx_service_ack = 1'b0;
        rx_is_ack = 1'b0;
        rx_payload = 64'h0;
    end
    task automatic send(input logic [7:0] c, input logic s,
                        input logic [15:0] p);
        @(posedge pclk);
        rx_valid       <= 1'b1;
        rx_cmd         <= c;
        rx_service_ack <= s;
        rx_payload     <= {48'h0, p};
        do @(posedge pclk); while (rx_ready !== 1'b1);
        rx_valid   <= 1'b0;
        // released lines must not keep looking valid
        rx_cmd     <= ~c;
        rx_payload <= ~rx_payload;
    endtask
    task automatic ack;
        @(posedge pclk);
        rx_valid  <= 1'b1;
        rx_is_ack <= 1'b1;
        do @(posedge pclk); while (rx_ready !== 1'b1);
        rx_valid  <= 1'b0;
        rx_is_ack <= 1'b0;
    endtask
endmodule // prcp_remote_node

// ---- verification/tb_powerline_remote_command_processor.sv ----
`timescale 1ns/1ps
module tb_powerline_remote_command_processor;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, rx_valid, rx_svc, rx_is_ack;
    logic rx_ready, tx_valid, tx_ack, host_event, cd_en, e;
    logic [7:0] paddr = 8'h00, rx_cmd;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [63:0] rx_payload, tx_data;
    logic [3:0] tx_len;
    logic [2:0] level;
    logic [51:0] rows [21];
    int err_total = 0, total_checks = 0, cyc = 0;
    always #2 pclk = ~pclk;
    prcp_command_processor #(.ACK_CYC(20), .RESP_CYC(40)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
        .rx_cmd(rx_cmd), .rx_service_ack(rx_svc), .rx_is_ack(rx_is_ack),
        .rx_payload(rx_payload), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_ack(tx_ack), .tx_len(tx_len), .tx_data(tx_data),
        .host_event(host_event), .carrier_detect_en(cd_en),
        .detect_level(level));
    prcp_remote_node PEER (.pclk(pclk), .rx_ready(rx_ready),
        .rx_valid(rx_valid), .rx_cmd(rx_cmd), .rx_service_ack(rx_svc),
        .rx_is_ack(rx_is_ack), .rx_payload(rx_payload));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] c, input logic s,
                       input logic [15:0] p);
        PEER.send(c, s, p);
        @(posedge pclk);
        #1;
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            end_sim();
        end
    end
    // {cmd, svc, payload, reply, len, data}; len F leaves len/data open
    initial begin
        rows = '{52'h07_0_0000_1_1_0005, 52'h04_0_1234_1_1_0000,
            52'h05_0_0000_1_1_0034, 52'h03_0_0001_1_1_0000,
            52'h04_0_1234_1_1_0000, 52'h05_0_0000_1_2_1234,
            52'h0C_0_0001_1_1_0000, 52'h0D_0_0006_1_1_0000,
            52'h0E_0_A55A_1_1_0000, 52'h0F_0_0000_1_2_A55A,
            52'h08_0_0000_1_1_005A, 52'h06_0_0000_1_8_CDEF,
            52'h07_0_0000_1_1_0033, 52'h09_0_0000_0_0_0000,
            52'h09_1_0000_1_F_0000, 52'h0B_0_0000_0_0_0000,
            52'h20_0_0000_0_0_0000, 52'h30_0_0000_0_0_0000,
            52'h01_0_0000_1_1_0000, 52'h05_0_0000_0_0_0000,
            52'h0F_0_0000_0_0_0000};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        chk({cd_en, level}, 64'h8);
        foreach (rows[i]) begin
            cmd(rows[i][51:44], rows[i][40], rows[i][39:24]);
            chk(tx_valid, rows[i][20]);
            chk(tx_ack, rows[i][40] & rows[i][20]);
            e = rows[i][51:44] inside {[8'h10:8'h2F]};
            chk(host_event, !e);
            if (rows[i][20] && rows[i][19:16] != 4'hF) begin
                chk(tx_len, rows[i][19:16]);
                chk(tx_data[15:0] & (rows[i][19:16] == 4'h1 ?
                    16'h00FF : 16'hFFFF), rows[i][15:0]);
            end
        end
        chk({cd_en, level}, 64'h6);
        apb(1'b1, 8'h00, 32'hB0);
        cmd(8'h0D, 1'b0, 16'h0001);
        chk({tx_valid, tx_data[7:0], level}, 64'h80E);
        apb(1'b0, 8'h00, 32'h0);
        chk(r, 32'hB0);
        apb(1'b1, 8'h1C, 32'h3);
        repeat (50) @(posedge pclk);
        apb(1'b0, 8'h18, 32'h0);
        chk(r[3:2], 2'h3);
        apb(1'b1, 8'h18, 32'h1F);
        apb(1'b1, 8'h1C, 32'h3);
        PEER.ack();
        cmd(8'h0B, 1'b0, 16'h0000);
        repeat (50) @(posedge pclk);
        apb(1'b0, 8'h18, 32'h0);
        chk(r[6:2], 5'h04);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        chk({cd_en, level, rx_ready}, 64'h11);
        apb(1'b0, 8'h40, 32'h0);
        chk(e, 1'b1);
        end_sim();
    end
endmodule // tb_powerline_remote_command_processor

// ---- verilog/prcp_command_processor.sv ----
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
module prcp_command_processor #(
    parameter int unsigned ACK_CYC    = prcp_pkg::ACK_TIMEOUT_CYC,
    parameter int unsigned RESP_CYC   = prcp_pkg::RESP_TIMEOUT_CYC,
    parameter logic [7:0]  REVISION   = 8'h5A, // arbitrary value
    parameter logic [63:0] HW_ID      = 64'h0123_4567_89AB_CDEF // arbitrary
) (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // received command from packet layer
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_cmd,
    input  wire logic        rx_service_ack,
    input  wire logic        rx_is_ack,
    input  wire logic [63:0] rx_payload,
    output logic             rx_ready,
    // reply towards packet layer
    output logic             tx_valid,
    output logic             tx_ack,
    output logic      [3:0]  tx_len,
    output logic      [63:0] tx_data,
    // host notification and settings
    output logic             host_event,
    output logic             carrier_detect_en,
    output logic      [2:0]  detect_level
);
    if (ACK_CYC < 1 || RESP_CYC < 1) begin : g_chk
        $error("timeout counts must be at least one cycle");
    end

    prcp_pkg::prcp_state_e state_ff, nxt_state;
    logic [7:0]  cfg_ff;
    logic [15:0] node_id_ff;
    logic [7:0]  grp_single_ff, grp_multi_ff;
    logic [7:0]  cmd_ff;
    logic [63:0] pay_ff;
    logic        svc_ff;
    logic [prcp_pkg::ST_STICKY_N-1:0] sticky_ff, st_set, st_clr;
    logic        ack_wait_ff, resp_wait_ff;
    logic [31:0] ack_cnt_ff, resp_cnt_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff, pslverr_ff;
    logic        tx_valid_ff, tx_ack_ff, host_event_ff, rx_ready_ff;
    logic [3:0]  tx_len_ff;
    logic [63:0] tx_data_ff;

    wire locked    = cfg_ff[prcp_pkg::CFG_LOCK];
    wire reply_en  = cfg_ff[prcp_pkg::CFG_REPLY_EN];
    wire wide      = cfg_ff[prcp_pkg::CFG_WIDE];
    wire exec      = (state_ff == prcp_pkg::PS_EXEC);
    wire is_set    = cmd_ff == prcp_pkg::CMD_SET_REPLY_EN
                  || (cmd_ff >= prcp_pkg::CMD_SET_WIDE_ADDR
                      && cmd_ff <= prcp_pkg::CMD_ASSIGN_NODE_ID)
                  || (cmd_ff >= prcp_pkg::CMD_SET_CARRIER
                      && cmd_ff <= prcp_pkg::CMD_SET_GROUPS);
    wire is_query  = (cmd_ff >= prcp_pkg::CMD_QUERY_NODE_ID
                      && cmd_ff <= prcp_pkg::CMD_QUERY_REVISION)
                  || cmd_ff == prcp_pkg::CMD_QUERY_GROUPS;
    wire is_data   = cmd_ff >= prcp_pkg::CMD_PUSH_PAYLOAD
                  && cmd_ff <= prcp_pkg::CMD_ANSWER_PAYLOAD;
    wire is_user   = cmd_ff >= prcp_pkg::CMD_USER_FIRST;
    wire apply_set = exec && is_set && !locked;

    wire apb_setup = psel && !penable;
    wire apb_wr    = psel && penable && pready_ff && pwrite;
    wire wr_cfg    = apb_wr && paddr == prcp_pkg::OFS_NODE_CFG;
    wire wr_id     = apb_wr && paddr == prcp_pkg::OFS_NODE_ID;
    wire wr_grp    = apb_wr && paddr == prcp_pkg::OFS_GROUPS;
    wire wr_st     = apb_wr && paddr == prcp_pkg::OFS_STATUS;
    wire wr_wait   = apb_wr && paddr == prcp_pkg::OFS_WAIT_CTL;
    wire ack_seen  = rx_valid && rx_ready_ff && rx_is_ack;
    wire resp_seen = exec && cmd_ff == prcp_pkg::CMD_ANSWER_PAYLOAD;
    wire take      = rx_valid && rx_ready_ff && !rx_is_ack;

    // command sequencer: capture, execute, emit reply
    always_comb begin
        case (state_ff)
            prcp_pkg::PS_IDLE:
                nxt_state = take ? prcp_pkg::PS_EXEC : prcp_pkg::PS_IDLE;
            prcp_pkg::PS_EXEC:  nxt_state = prcp_pkg::PS_REPLY;
            default:            nxt_state = prcp_pkg::PS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff    <= prcp_pkg::PS_IDLE;
            rx_ready_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            rx_ready_ff <= (nxt_state == prcp_pkg::PS_IDLE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ff <= 8'h00;
            pay_ff <= 64'h0;
            svc_ff <= 1'b0;
        end else if (state_ff == prcp_pkg::PS_IDLE && take) begin
            cmd_ff <= rx_cmd;
            pay_ff <= rx_payload;
            svc_ff <= rx_service_ack;
        end
    end

    // remote set commands take priority over a software write that lands
    // in the same cycle; the software write in that cycle is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= prcp_pkg::CFG_RST;
        end else if (apply_set) begin
            case (cmd_ff)
                prcp_pkg::CMD_SET_REPLY_EN:
                    cfg_ff[prcp_pkg::CFG_REPLY_EN] <= pay_ff[0];
                prcp_pkg::CMD_SET_WIDE_ADDR:
                    cfg_ff[prcp_pkg::CFG_WIDE] <= pay_ff[0];
                prcp_pkg::CMD_SET_CARRIER:
                    cfg_ff[prcp_pkg::CFG_CD_EN] <= !pay_ff[0];
                prcp_pkg::CMD_SET_LEVEL:
                    cfg_ff[prcp_pkg::CFG_LVL_MSB:prcp_pkg::CFG_LVL_LSB]
                        <= pay_ff[2:0];
                default: ;
            endcase
        end else if (wr_cfg) begin
            cfg_ff <= pwdata[7:0] & prcp_pkg::CFG_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            node_id_ff <= 16'h0000;
        end else if (apply_set && cmd_ff == prcp_pkg::CMD_ASSIGN_NODE_ID) begin
            node_id_ff <= wide ? pay_ff[15:0]
                               : {8'h00, pay_ff[7:0]};
        end else if (wr_id) begin
            node_id_ff <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grp_single_ff <= 8'h00;
            grp_multi_ff  <= 8'h00;
        end else if (apply_set && cmd_ff == prcp_pkg::CMD_SET_GROUPS) begin
            grp_single_ff <= pay_ff[7:0];
            grp_multi_ff  <= pay_ff[15:8];
        end else if (wr_grp) begin
            grp_single_ff <= pwdata[7:0];
            grp_multi_ff  <= pwdata[15:8];
        end
    end

    // reply builder; reserved codes match no branch and stay silent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid_ff <= 1'b0;
            tx_ack_ff   <= 1'b0;
            tx_len_ff   <= prcp_pkg::LEN_NONE;
            tx_data_ff  <= 64'h0;
        end else begin
            tx_valid_ff <= 1'b0;
            tx_ack_ff   <= 1'b0;
            if (exec) begin
                tx_len_ff  <= prcp_pkg::LEN_NONE;
                tx_data_ff <= 64'h0;
                if (is_set) begin
                    tx_valid_ff <= 1'b1;
                    tx_len_ff   <= prcp_pkg::LEN_BYTE;
                    tx_data_ff[7:0] <= locked ? prcp_pkg::RESP_DENIED
                                              : prcp_pkg::RESP_SUCCESS;
                end else if (is_query && reply_en) begin
                    tx_valid_ff <= 1'b1;
                    case (cmd_ff)
                        prcp_pkg::CMD_QUERY_NODE_ID: begin
                            tx_len_ff <= wide ? prcp_pkg::LEN_WORD
                                              : prcp_pkg::LEN_BYTE;
                            tx_data_ff[15:0] <= wide ? node_id_ff
                                : {8'h00, node_id_ff[7:0]};
                        end
                        prcp_pkg::CMD_QUERY_HW_ID: begin
                            tx_len_ff  <= prcp_pkg::LEN_HWID;
                            tx_data_ff <= HW_ID;
                        end
                        prcp_pkg::CMD_QUERY_CONFIG: begin
                            tx_len_ff       <= prcp_pkg::LEN_BYTE;
                            tx_data_ff[7:0] <= cfg_ff;
                        end
                        prcp_pkg::CMD_QUERY_REVISION: begin
                            tx_len_ff       <= prcp_pkg::LEN_BYTE;
                            tx_data_ff[7:0] <= REVISION;
                        end
                        default: begin
                            tx_len_ff        <= prcp_pkg::LEN_WORD;
                            tx_data_ff[15:0] <= {grp_multi_ff,
                                                 grp_single_ff};
                        end
                    endcase
                end else if (is_data && cmd_ff != prcp_pkg::CMD_ANSWER_PAYLOAD
                             && svc_ff) begin
                    tx_valid_ff <= 1'b1;
                    tx_ack_ff   <= 1'b1;
                end
            end
        end
    end

    // host notification: completed control exchange, data for the host, or a watchdog result
    always_comb begin
        st_set = '0;
        st_set[prcp_pkg::ST_CMD_DONE]  = exec && (is_set || is_query);
        st_set[prcp_pkg::ST_HOST_DATA] = exec && (is_data || is_user);
        st_set[prcp_pkg::ST_NO_ACK]    = ack_wait_ff
                                      && ack_cnt_ff == 32'd1 && !ack_seen;
        st_set[prcp_pkg::ST_NO_RESP]   = resp_wait_ff
                                      && resp_cnt_ff == 32'd1 && !resp_seen;
        st_set[prcp_pkg::ST_RESP_OK]   = resp_wait_ff && resp_seen;
        st_clr = wr_st ? pwdata[prcp_pkg::ST_STICKY_N-1:0] : '0;
    end

    for (genvar i = 0; i < prcp_pkg::ST_STICKY_N; i++) begin : g_sticky
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sticky_ff[i] <= 1'b0;
            end else begin
                sticky_ff[i] <= st_set[i] | (sticky_ff[i] & ~st_clr[i]);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_event_ff <= 1'b0;
        end else begin
            host_event_ff <= |st_set;
        end
    end

    // initiator watchdogs, armed by software once its packet has gone out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_wait_ff <= 1'b0;
            ack_cnt_ff  <= 32'd0;
        end else if (wr_wait && pwdata[prcp_pkg::WAIT_ACK_BIT]) begin
            ack_wait_ff <= 1'b1;
            ack_cnt_ff  <= ACK_CYC;
        end else if (ack_wait_ff) begin
            if (ack_seen || ack_cnt_ff == 32'd1) begin
                ack_wait_ff <= 1'b0;
            end
            ack_cnt_ff <= ack_cnt_ff - 32'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_wait_ff <= 1'b0;
            resp_cnt_ff  <= 32'd0;
        end else if (wr_wait && pwdata[prcp_pkg::WAIT_RESP_BIT]) begin
            resp_wait_ff <= 1'b1;
            resp_cnt_ff  <= RESP_CYC;
        end else if (resp_wait_ff) begin
            if (resp_seen || resp_cnt_ff == 32'd1) begin
                resp_wait_ff <= 1'b0;
            end
            resp_cnt_ff <= resp_cnt_ff - 32'd1;
        end
    end

    // apb: data prepared in setup, answered in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else begin
            pready_ff  <= apb_setup;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
            if (apb_setup) begin
                case (paddr)
                    prcp_pkg::OFS_NODE_CFG: prdata_ff[7:0]  <= cfg_ff;
                    prcp_pkg::OFS_NODE_ID:  prdata_ff[15:0] <= node_id_ff;
                    prcp_pkg::OFS_GROUPS:
                        prdata_ff[15:0] <= {grp_multi_ff, grp_single_ff};
                    prcp_pkg::OFS_REVISION: prdata_ff[7:0]  <= REVISION;
                    prcp_pkg::OFS_HWID_LO:  prdata_ff <= HW_ID[31:0];
                    prcp_pkg::OFS_HWID_HI:  prdata_ff <= HW_ID[63:32];
                    prcp_pkg::OFS_STATUS: begin
                        prdata_ff[prcp_pkg::ST_STICKY_N-1:0] <= sticky_ff;
                        prdata_ff[prcp_pkg::ST_ACK_WAIT]  <= ack_wait_ff;
                        prdata_ff[prcp_pkg::ST_RESP_WAIT] <= resp_wait_ff;
                        prdata_ff[prcp_pkg::ST_CODE_LSB+:8] <= cmd_ff;
                    end
                    prcp_pkg::OFS_WAIT_CTL: prdata_ff <= 32'h0;
                    default: pslverr_ff <= 1'b1;
                endcase
            end
        end
    end

    assign prdata            = prdata_ff;
    assign pready            = pready_ff;
    assign pslverr           = pslverr_ff;
    assign rx_ready          = rx_ready_ff;
    assign tx_valid          = tx_valid_ff;
    assign tx_ack            = tx_ack_ff;
    assign tx_len            = tx_len_ff;
    assign tx_data           = tx_data_ff;
    assign host_event        = host_event_ff;
    assign carrier_detect_en = cfg_ff[prcp_pkg::CFG_CD_EN];
    assign detect_level = cfg_ff[prcp_pkg::CFG_LVL_MSB:prcp_pkg::CFG_LVL_LSB];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    reply_en_only_a: assert property (
        exec && cmd_ff == prcp_pkg::CMD_SET_REPLY_EN && !locked
        |=> cfg_ff[7:1] == $past(cfg_ff[7:1])
            && cfg_ff[0] == $past(pay_ff[0]))
        else $error("reply enable command touched other bits");
    lock_denies_a: assert property (
        exec && is_set && locked
        |=> tx_valid && tx_data[7:0] == prcp_pkg::RESP_DENIED
            && $stable(cfg_ff) && $stable(node_id_ff))
        else $error("locked set command not denied");
    unlock_ok_a: assert property (
        exec && is_set && !locked
        |=> tx_valid && tx_len == 4'h1 && tx_data[7:0] == 8'h00)
        else $error("unlocked set command not acknowledged");
    id_width_a: assert property (
        exec && cmd_ff == prcp_pkg::CMD_ASSIGN_NODE_ID && !locked && !wide
        |=> node_id_ff == {8'h00, $past(pay_ff[7:0])})
        else $error("narrow id not stored");
    silent_query_a: assert property (
        exec && is_query && !reply_en |=> !tx_valid)
        else $error("query answered while reply disabled");
    hwid_reply_a: assert property (
        exec && cmd_ff == prcp_pkg::CMD_QUERY_HW_ID && reply_en
        |=> tx_valid && tx_len == 4'h8 && tx_data == HW_ID)
        else $error("hw id reply wrong");
    push_ack_a: assert property (
        exec && cmd_ff == prcp_pkg::CMD_PUSH_PAYLOAD
        |=> tx_valid == $past(svc_ff) && tx_ack == $past(svc_ff))
        else $error("push payload ack wrong");
    answer_silent_a: assert property (
        exec && cmd_ff == prcp_pkg::CMD_ANSWER_PAYLOAD
        |=> !tx_valid ##1 sticky_ff[prcp_pkg::ST_HOST_DATA])
        else $error("answer payload produced a reply");
    carrier_inv_a: assert property (
        exec && cmd_ff == prcp_pkg::CMD_SET_CARRIER && !locked
        |=> carrier_detect_en == !$past(pay_ff[0]))
        else $error("carrier detect polarity wrong");
    reserved_drop_a: assert property (
        exec && cmd_ff >= 8'h10 && cmd_ff < 8'h30
        |=> !tx_valid && $stable(cfg_ff) && $stable(grp_single_ff))
        else $error("reserved command had an effect");
    no_ack_flag_a: assert property (
        ack_wait_ff && ack_cnt_ff == 32'd1 && !ack_seen
        |=> !ack_wait_ff && sticky_ff[prcp_pkg::ST_NO_ACK])
        else $error("ack timeout not flagged");
    no_resp_flag_a: assert property (
        resp_wait_ff && resp_cnt_ff == 32'd1 && !resp_seen
        |=> !resp_wait_ff && sticky_ff[prcp_pkg::ST_NO_RESP])
        else $error("response timeout not flagged");

    set_cmd_c:   cover property (exec && is_set && !locked);
    query_c:     cover property (exec && is_query && reply_en);
    ack_miss_c:  cover property (st_set[prcp_pkg::ST_NO_ACK]);
    resp_good_c: cover property (st_set[prcp_pkg::ST_RESP_OK]);
endmodule // prcp_command_processor

// ---- verilog/prcp_pkg.sv ----
package prcp_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_NODE_CFG = 8'h00;
    localparam logic [7:0] OFS_NODE_ID  = 8'h04;
    localparam logic [7:0] OFS_GROUPS   = 8'h08;
    localparam logic [7:0] OFS_REVISION = 8'h0C;
    localparam logic [7:0] OFS_HWID_LO  = 8'h10;
    localparam logic [7:0] OFS_HWID_HI  = 8'h14;
    localparam logic [7:0] OFS_STATUS   = 8'h18;
    localparam logic [7:0] OFS_WAIT_CTL = 8'h1C;

    // node configuration register fields
    localparam int         CFG_REPLY_EN = 0;
    localparam int         CFG_WIDE     = 1;
    localparam int         CFG_CD_EN    = 2;
    localparam int         CFG_LVL_LSB  = 3;
    localparam int         CFG_LVL_MSB  = 5;
    localparam int         CFG_LOCK     = 7;
    localparam logic [7:0] CFG_RST      = 8'h05;
    localparam logic [7:0] CFG_WMASK    = 8'hBF;

    // status register: sticky bits then live wait flags
    localparam int ST_CMD_DONE  = 0;
    localparam int ST_HOST_DATA = 1;
    localparam int ST_NO_ACK    = 2;
    localparam int ST_NO_RESP   = 3;
    localparam int ST_RESP_OK   = 4;
    localparam int ST_STICKY_N  = 5;
    localparam int ST_ACK_WAIT  = 5;
    localparam int ST_RESP_WAIT = 6;
    localparam int ST_CODE_LSB  = 8;
    localparam int WAIT_ACK_BIT  = 0;
    localparam int WAIT_RESP_BIT = 1;

    // incoming command codes
    localparam logic [7:0] CMD_SET_REPLY_EN   = 8'h01;
    localparam logic [7:0] CMD_SET_WIDE_ADDR  = 8'h03;
    localparam logic [7:0] CMD_ASSIGN_NODE_ID = 8'h04;
    localparam logic [7:0] CMD_QUERY_NODE_ID  = 8'h05;
    localparam logic [7:0] CMD_QUERY_HW_ID    = 8'h06;
    localparam logic [7:0] CMD_QUERY_CONFIG   = 8'h07;
    localparam logic [7:0] CMD_QUERY_REVISION = 8'h08;
    localparam logic [7:0] CMD_PUSH_PAYLOAD   = 8'h09;
    localparam logic [7:0] CMD_PULL_PAYLOAD   = 8'h0A;
    localparam logic [7:0] CMD_ANSWER_PAYLOAD = 8'h0B;
    localparam logic [7:0] CMD_SET_CARRIER    = 8'h0C;
    localparam logic [7:0] CMD_SET_LEVEL      = 8'h0D;
    localparam logic [7:0] CMD_SET_GROUPS     = 8'h0E;
    localparam logic [7:0] CMD_QUERY_GROUPS   = 8'h0F;
    localparam logic [7:0] CMD_USER_FIRST     = 8'h30;

    localparam logic [7:0] RESP_SUCCESS = 8'h00;
    localparam logic [7:0] RESP_DENIED  = 8'h01;

    // reply lengths in bytes
    localparam logic [3:0] LEN_NONE = 4'h0;
    localparam logic [3:0] LEN_BYTE = 4'h1;
    localparam logic [3:0] LEN_WORD = 4'h2;
    localparam logic [3:0] LEN_HWID = 4'h8;

    // timeouts
    localparam int unsigned CLK_KHZ         = 250000;
    localparam int unsigned ACK_TIMEOUT_MS  = 500;
    localparam int unsigned RESP_TIMEOUT_MS = 1500;
    localparam int unsigned ACK_TIMEOUT_CYC = ACK_TIMEOUT_MS * CLK_KHZ;
    localparam int unsigned RESP_TIMEOUT_CYC = RESP_TIMEOUT_MS * CLK_KHZ;

    typedef enum logic [1:0] {
        PS_IDLE  = 2'b00,
        PS_EXEC  = 2'b01,
        PS_REPLY = 2'b11
    } prcp_state_e;
endpackage
